//--- rtl/sac_conv_ctrl.sv
// Purpose : conversion sequencing of a 10-bit serial successive-approximation converter
// Assumes : serial clock and convert-start are asynchronous pins, compIn is on-chip logic
// Notes   : serial clock must be well below sys_clk/4 so each edge is seen after synchronising
// How it works
// - convert-start falling edge holds the sample and starts a conversion
// - data output changes only on convert-start falling edges and serial clock rising edges, one bit per rising edge
// - a conversion takes sixteen serial clock periods, paced by the host clock
// - track/hold returns to tracking on the fourteenth rising edge
// - at power-up the track/hold tracks immediately
// - between conversions the block idles in done; a start rise or float in done, or a power-down request, moves it to acquisition
// - leaving partial power-down costs sixteen serial clock restart edges
// - successive approximation resolves a 10-bit result sent serially
// - only serial clock, convert-start and data output form the link
// - three leading zeros, MSB at fourth rising edge, then two sub-bits
// - start low past sixteenth falling edge floats data on next rising edge
// - convert-start falling edge drives data output actively low
// - unipolar codes straight binary, bipolar codes two's complement
`timescale 1ns/1ps
`include "sac_defines.svh"

module sac_conv_ctrl
  import sac_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic                     serialClkPin,
  input  wire logic                     convertStartIn,
  input  wire logic                     bipolarPin,
  input  wire logic                     compIn,
  input  wire logic                     resultReady,
  output logic                          dataOut,
  output logic                          dataOutEn,
  output logic                          trackMode,
  output logic [`SAC_RESULT_W-1:0]      dacCode,
  output sac_pwr_e                      powerMode,
  output logic                          restartBusy,
  output sac_result_s                   resultWord,
  output logic                          resultValid,
  output logic                          resultBufReady
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: the first stage feeds only the second
  logic                    sclkS1_q, sclkS2_q, sclkPrev_q;
  logic                    cnvS1_q, cnvS2_q, cnvPrev_q;
  logic                    bipS1_q, bipS2_q;

  always_ff @(posedge sys_clk) begin
    sclkS1_q   <= serialClkPin;
    sclkS2_q   <= sclkS1_q;
    sclkPrev_q <= sclkS2_q;
    cnvS1_q    <= convertStartIn;
    cnvS2_q    <= cnvS1_q;
    cnvPrev_q  <= cnvS2_q;
    bipS1_q    <= bipolarPin;
    bipS2_q    <= bipS1_q;
  end

  // edge detect on the second stage only
  wire sclkRise = sclkS2_q & ~sclkPrev_q;
  wire sclkFall = ~sclkS2_q & sclkPrev_q;
  wire cnvFall  = ~cnvS2_q & cnvPrev_q;
  wire cnvRise  = cnvS2_q & ~cnvPrev_q;

  ////////////////////////////////////////////////////////////////////////////////
  // state and edge count registers
  sac_state_e               state_q, state_d;
  logic [`SAC_CNT_W-1:0]    edgeCnt_q;
  logic                     floatArm_q;
  logic                     dataOut_q, dataOutEn_q, trackMode_q;
  logic [`SAC_RESULT_W-1:0] sarCode_q;
  sac_pwr_e                 powerMode_q;
  logic [`SAC_CNT_W-1:0]    restartCnt_q;
  logic                     bipolar_q;

  // edge number that this rising edge makes, counted from the start
  wire [`SAC_CNT_W-1:0] edgeNext   = edgeCnt_q + `SAC_CNT_W'(1);
  wire                  inConv     = (state_q == SAC_CONV);
  wire                  convRise   = inConv & sclkRise;
  wire                  isDataEdge = (edgeNext >= `SAC_EDGE_MSB) && (edgeNext <= `SAC_EDGE_LSB);
  wire                  isMsbEdge  = (edgeNext == `SAC_EDGE_MSB);
  wire                  isSubEdge  = (edgeNext == `SAC_EDGE_SUB_HIGH) || (edgeNext == `SAC_EDGE_SUB_LOW);
  wire                  reachTrack = convRise && (edgeNext == `SAC_EDGE_TRACK);
  wire                  reachLast  = convRise && (edgeNext == `SAC_EDGE_LAST);
  // start raised after the 3rd and before the 14th edge asks for lower power
  wire                  ppdRequest = inConv && cnvRise && (edgeCnt_q >= 5'h03) && (edgeCnt_q < `SAC_EDGE_TRACK);
  wire                  pwrExit    = reachTrack && (powerMode_q != SAC_PWR_NORMAL);
  wire                  floatNow   = floatArm_q && (sclkRise || cnvRise) && !cnvFall;

  // bit presented on this edge: zeros, result MSB first, sub-bits, trailing zero
  wire msbFlip  = isMsbEdge & bipolar_q;
  wire bitValue = (isDataEdge | isSubEdge) ? (compIn ^ msbFlip) : 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer next state; a new start wins over anything else
  always_comb begin
    state_d = state_q;
    case (state_q)
      SAC_ACQ: begin
        if (cnvFall) state_d = SAC_CONV;
      end
      SAC_CONV: begin
        if (cnvFall)         state_d = SAC_CONV;
        else if (ppdRequest) state_d = SAC_ACQ;
        else if (reachLast)  state_d = SAC_DONE;
      end
      SAC_DONE: begin
        if (cnvFall)       state_d = SAC_CONV;
        else if (floatNow) state_d = SAC_ACQ;
        else if (cnvRise)  state_d = SAC_ACQ;
      end
      default: state_d = SAC_ACQ;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) state_q <= SAC_ACQ;
    else     state_q <= state_d;
  end

  // rising edge counter, cleared by each start
  always_ff @(posedge sys_clk) begin
    if (rst)                               edgeCnt_q <= '0;
    else if (cnvFall)                      edgeCnt_q <= '0;
    else if (convRise)                     edgeCnt_q <= edgeNext;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // track/hold: tracking from power-up, hold at start, tracking at 14th edge
  always_ff @(posedge sys_clk) begin
    if (rst)             trackMode_q <= 1'b1;
    else if (cnvFall)    trackMode_q <= 1'b0;
    else if (reachTrack) trackMode_q <= 1'b1;
  end

  // data pin: driven low at start, updated only on rising edges
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dataOut_q   <= 1'b0;
      dataOutEn_q <= 1'b0;
    end else if (cnvFall) begin
      dataOut_q   <= 1'b0;
      dataOutEn_q <= 1'b1;
    end else if (ppdRequest || floatNow) begin
      dataOutEn_q <= 1'b0;
    end else if (convRise) begin
      dataOut_q   <= bitValue;
    end else if (state_q == SAC_DONE && sclkRise) begin
      dataOut_q   <= 1'b0;
    end
  end

  // float is armed by a falling edge seen at or after the 16th with start still low
  always_ff @(posedge sys_clk) begin
    if (rst || cnvFall)                               floatArm_q <= 1'b0;
    else if (state_q == SAC_DONE && sclkFall && !cnvS2_q) floatArm_q <= 1'b1;
    else if (state_q != SAC_DONE)                     floatArm_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // successive approximation: one decision per data edge, next trial bit set
  logic [`SAC_RESULT_W-1:0] sarCode_d;
  wire  [`SAC_RESULT_W-1:0] sarReset = `SAC_SAR_RESET;   // start code: only the top trial bit set
  genvar gi;
  generate
    for (gi = 0; gi < `SAC_RESULT_W; gi++) begin : g_sar
      wire decide = convRise && (edgeNext == (`SAC_EDGE_LSB - `SAC_CNT_W'(gi)));
      wire trial;
      if (gi == `SAC_RESULT_W-1) begin : g_top
        assign trial = 1'b0;
      end else begin : g_low
        assign trial = convRise && (edgeNext == (`SAC_EDGE_LSB - `SAC_CNT_W'(gi + 1)));
      end
      assign sarCode_d[gi] = cnvFall ? sarReset[gi] :
                             decide  ? compIn :
                             trial   ? 1'b1 : sarCode_q[gi];
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (rst) sarCode_q <= `SAC_SAR_RESET;
    else     sarCode_q <= sarCode_d;
  end

  // coding sense is caught at each start, never mid-conversion
  always_ff @(posedge sys_clk) begin
    if (rst)          bipolar_q <= 1'b0;
    else if (cnvFall) bipolar_q <= bipS2_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // power modes: each early raise steps one mode deeper until full, a conversion reaching the 14th edge wakes up
  always_ff @(posedge sys_clk) begin
    if (rst)                                            powerMode_q <= SAC_PWR_NORMAL;
    else if (pwrExit)                                   powerMode_q <= SAC_PWR_NORMAL;
    else if (ppdRequest && powerMode_q == SAC_PWR_NORMAL) powerMode_q <= SAC_PWR_PARTIAL;
    else if (ppdRequest)                                powerMode_q <= SAC_PWR_FULL;
  end

  // restart latency after partial power-down, counted in serial clock edges;
  // the busy flag is registered from the next count so the pin comes from a flop
  logic [`SAC_CNT_W-1:0] restartCnt_d;
  logic                  restartBusy_q;
  wire                   restartLoad = pwrExit && (powerMode_q == SAC_PWR_PARTIAL);
  wire                   restartStep = sclkRise && (restartCnt_q != '0);

  assign restartCnt_d = restartLoad ? `SAC_RESTART_EDGES :
                        restartStep ? restartCnt_q - `SAC_CNT_W'(1) : restartCnt_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      restartCnt_q  <= '0;
      restartBusy_q <= 1'b0;
    end else begin
      restartCnt_q  <= restartCnt_d;
      restartBusy_q <= (restartCnt_d != '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // two-entry result buffer; slot 0 is the head so the output is a flop
  sac_result_s slot_q [2];
  logic [1:0]  fill_q, fill_d;
  wire         lsbDone  = convRise && (edgeNext == `SAC_EDGE_LSB);
  wire         wordOk   = (powerMode_q == SAC_PWR_NORMAL) && (restartCnt_q == '0);
  wire         pushReq  = lsbDone && wordOk;
  wire         doPush   = pushReq && (fill_q != 2'h2);   // full buffer drops the word
  wire         doPop    = resultReady && (fill_q != 2'h0);
  wire [1:0]   afterPop = fill_q - {1'b0, doPop};
  sac_result_s newWord;
  logic        resultValid_q, bufReady_q;

  assign newWord.bipolar = bipolar_q;
  // bipolar words leave in two's complement: the offset-binary top bit is inverted
  assign newWord.code    = {sarCode_q[`SAC_RESULT_W-1] ^ bipolar_q, sarCode_q[`SAC_RESULT_W-2:1], compIn};
  assign fill_d          = afterPop + {1'b0, doPush};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fill_q        <= 2'h0;
      resultValid_q <= 1'b0;
      bufReady_q    <= 1'b1;
      slot_q[0]     <= '0;
      slot_q[1]     <= '0;
    end else begin
      fill_q        <= fill_d;
      resultValid_q <= (fill_d != 2'h0);
      bufReady_q    <= (fill_d != 2'h2);
      if (doPop) slot_q[0] <= slot_q[1];
      if (doPush) slot_q[afterPop[0]] <= newWord;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign dataOut        = dataOut_q;
  assign dataOutEn      = dataOutEn_q;
  assign trackMode      = trackMode_q;
  assign dacCode        = sarCode_q;
  assign powerMode      = powerMode_q;
  assign restartBusy    = restartBusy_q;
  assign resultWord     = slot_q[0];
  assign resultValid    = resultValid_q;
  assign resultBufReady = bufReady_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence seqStart;
    cnvFall;
  endsequence

  sequence seqMsbEdge;
    convRise && !cnvFall && !ppdRequest && (edgeCnt_q == 5'h03);
  endsequence

  AST_HOLD_ON_START: assert property (seqStart |=> !trackMode_q && dataOutEn_q && !dataOut_q)
    else $error("start did not hold and drive low");
  AST_TRACK_AT_14: assert property (reachTrack && !cnvFall |=> trackMode_q && $past(edgeCnt_q) == 5'h0D)
    else $error("tracking not resumed at edge 14");
  AST_DOUT_ON_RISE: assert property ($changed(dataOut_q) |-> $past(sclkRise) || $past(cnvFall))
    else $error("data changed without a rising edge");
  AST_LEADING_ZERO: assert property (convRise && edgeCnt_q < 5'h03 && !cnvFall && !ppdRequest
                                     |=> !dataOut_q)
    else $error("leading zero missing");
  AST_MSB_VALUE: assert property (seqMsbEdge |=> dataOut_q == ($past(compIn) ^ bipolar_q))
    else $error("msb value or coding wrong");
  AST_DONE_AT_16: assert property (reachLast && !cnvFall |=> state_q == SAC_DONE ##0 edgeCnt_q == 5'h10)
    else $error("conversion not done at edge 16");
  AST_FLOAT: assert property (floatNow |=> !dataOutEn_q)
    else $error("data output did not float");
  AST_POWERUP_TRACK: assert property ($fell(rst) |-> trackMode_q && !dataOutEn_q)
    else $error("not tracking after reset");
  AST_RESTART: assert property (pwrExit && powerMode_q == SAC_PWR_PARTIAL |=> restartCnt_q == 5'h10)
    else $error("restart latency not loaded");
  AST_TRACK_UNTIL_START: assert property ($fell(trackMode_q) |-> $past(cnvFall))
    else $error("hold entered without a start");

endmodule // sac_conv_ctrl

//--- rtl/sac_defines.svh
// Purpose : timing counts, bit positions and reset values of the conversion control
// Assumes : sys_clk at 100 MHz (10 ns period)
// Notes   : counts are serial clock rising edges unless named as cycles
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

`define SAC_RESULT_W        10
`define SAC_CNT_W           5
`define SAC_EDGE_MSB        5'h04
`define SAC_EDGE_LSB        5'h0D
`define SAC_EDGE_TRACK      5'h0E
`define SAC_EDGE_SUB_HIGH   5'h0E
`define SAC_EDGE_SUB_LOW    5'h0F
`define SAC_EDGE_LAST       5'h10
`define SAC_EDGE_PPD_FIRST  5'h04
`define SAC_SAR_RESET       10'h200
`define SAC_RESTART_EDGES   5'h10
`define SAC_CLK_PERIOD_NS   10
`define SAC_ACQ_NS          125
`define SAC_ACQ_CYC         ((`SAC_ACQ_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)

`endif

//--- rtl/sac_pkg.sv
// Purpose : types shared by the conversion control
// Assumes : sac_defines.svh gives the widths
// Notes   : none
`include "sac_defines.svh"

package sac_pkg;

  // gray coded along acquire -> convert -> done
  typedef enum logic [1:0] {
    SAC_ACQ  = 2'h0,
    SAC_CONV = 2'h1,
    SAC_DONE = 2'h3
  } sac_state_e;

  typedef enum logic [1:0] {
    SAC_PWR_NORMAL  = 2'h0,
    SAC_PWR_PARTIAL = 2'h1,
    SAC_PWR_FULL    = 2'h2
  } sac_pwr_e;

  typedef struct packed {
    logic                      bipolar;
    logic [`SAC_RESULT_W-1:0]  code;
  } sac_result_s;

endpackage

//--- verif/sac_host_model.sv
// Purpose : host serial master driving the serial clock and convert-start pins
// Assumes : eight sys_clk per serial period, four high and four low
// Notes   : captures dataOut and trackMode at the end of each of the nEdges serial periods, not the added release period
`timescale 1ns/1ps

module sac_host_model (
  input  wire logic        sys_clk,
  output logic             serialClkPin,
  output logic             convertStartIn,
  input  wire logic        dataOut,
  input  wire logic        trackMode,
  output logic [15:0]      rxBits,
  output logic [15:0]      trackBits
);
  ////////////////////////////////////////////////////////////////////////////
  // idle: start high so the next fall is a clean trigger, clock parked low
  initial begin
    serialClkPin   = 1'b0;
    convertStartIn = 1'b1;
    rxBits         = 16'h0000;
    trackBits      = 16'h0000;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // one frame; riseAt 0 keeps start low past the last edge and adds one
  // rising edge so the output release can be seen
  task automatic frame(input int riseAt, input int nEdges);
    convertStartIn = 1'b0;
    tick(4);
    for (int k = 1; k <= nEdges; k++) begin
      serialClkPin = 1'b1;
      tick(2);
      if (k == riseAt) begin
        convertStartIn = 1'b1;
      end
      tick(2);
      serialClkPin = 1'b0;
      tick(4);
      rxBits    = {rxBits[14:0], dataOut};
      trackBits = {trackBits[14:0], trackMode};
    end
    if (riseAt == 0) begin
      serialClkPin = 1'b1;
      tick(4);
      serialClkPin = 1'b0;
      tick(4);
      convertStartIn = 1'b1;
    end
    // three serial periods of acquisition, well above the 125 ns floor
    tick(24);
  endtask
endmodule // sac_host_model

//--- verif/tb.sv
// Purpose : self-checking bench of the conversion control
// Assumes : comparator modelled from a random analog code against dacCode
// Notes   : sub-bits are masked since they follow the comparator after the result
`timescale 1ns/1ps

module tb;
  import sac_pkg::*;

  logic            sys_clk = 1'b0;
  logic            rst = 1'b1;
  logic            serialClkPin;
  logic            convertStartIn;
  logic            bipolarPin = 1'b0;
  logic            compIn;
  logic            resultReady = 1'b1;
  logic            dataOut;
  logic            dataOutEn;
  logic            trackMode;
  logic [9:0]      dacCode;
  sac_pwr_e        powerMode;
  logic            restartBusy;
  sac_result_s     resultWord;
  logic            resultValid;
  logic            resultBufReady;
  logic [15:0]     rxBits;
  logic [15:0]     trackBits;
  logic [9:0]      analog = 10'h000;
  logic            randReady = 1'b0;
  logic            fixReady = 1'b1;
  sac_result_s     expQ[$];
  int              n_errors = 0;
  int              compares = 0;

  always #5 sys_clk = ~sys_clk;

  // comparator stand-in: decision is live against the trial code
  assign compIn = (analog >= dacCode);

  sac_conv_ctrl sac_conv_ctrl_i (.sys_clk(sys_clk), .rst(rst), .serialClkPin(serialClkPin),
    .convertStartIn(convertStartIn), .bipolarPin(bipolarPin), .compIn(compIn),
    .resultReady(resultReady), .dataOut(dataOut), .dataOutEn(dataOutEn), .trackMode(trackMode),
    .dacCode(dacCode), .powerMode(powerMode), .restartBusy(restartBusy), .resultWord(resultWord),
    .resultValid(resultValid), .resultBufReady(resultBufReady));

  // a released data line reads as the inverse of its last level, so a late enable shows as bad bits
  sac_host_model sac_host_model_i (.sys_clk(sys_clk), .serialClkPin(serialClkPin),
    .convertStartIn(convertStartIn), .dataOut(dataOutEn ? dataOut : ~dataOut), .trackMode(trackMode),
    .rxBits(rxBits), .trackBits(trackBits));

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmpVec(input string name, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic cmpWord(input sac_result_s e, input sac_result_s g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error resultWord expected %h seen %h", e, g);
    end
  endtask

  task automatic finish_test;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // consumer ready: fixed level or random stalls, one driver only
  always @(posedge sys_clk) begin
    #1;
    resultReady = randReady ? 1'($urandom_range(0, 1)) : fixReady;
  end

  // result monitor takes the oldest noted word at every pop
  always @(posedge sys_clk) begin
    if (!rst && resultValid === 1'b1 && resultReady === 1'b1) begin
      if (expQ.size() == 0) begin
        n_errors++;
        $display("Error resultWord expected none seen %h", resultWord);
      end else begin
        cmpWord(expQ.pop_front(), resultWord);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one conversion with a random input and coding
  task automatic conv(input int riseAt, input bit push, input bit chk);
    logic [9:0] code;
    analog     = 10'($urandom);
    bipolarPin = 1'($urandom);
    code       = bipolarPin ? (analog ^ 10'h200) : analog;
    if (push) begin
      expQ.push_back({bipolarPin, code});
    end
    sac_host_model_i.frame(riseAt, 16);
    if (chk) begin
      cmpVec("frame", {3'h0, code, 3'h0}, rxBits & 16'hFFF9);
      cmpVec("track", 16'h0007, trackBits);
    end
  endtask

  initial begin
    #400000;
    n_errors++;
    $display("Error watchdog expected finish seen timeout");
    finish_test();
  end

  initial begin
    void'($urandom(21));
    repeat (20) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    cmpVec("trackReset", 16'h0001, {15'h0, trackMode});
    for (int i = 0; i < 4; i++) begin
      conv(15, 1'b1, 1'b1);
    end
    cmpVec("enCont", 16'h0001, {15'h0, dataOutEn});
    $display("test continuous done");
    conv(0, 1'b1, 1'b1);
    cmpVec("enRelease", 16'h0000, {15'h0, dataOutEn});
    $display("test release done");
    fixReady = 1'b0;
    conv(15, 1'b1, 1'b1);
    conv(15, 1'b1, 1'b1);
    cmpVec("bufFull", 16'h0000, {15'h0, resultBufReady});
    conv(15, 1'b0, 1'b1);
    randReady = 1'b1;
    repeat (40) @(posedge sys_clk);
    #1;
    cmpVec("bufEmpty", 16'h0000, {15'h0, resultValid});
    $display("test buffer done");
    sac_host_model_i.frame(5, 8);
    cmpVec("pwrPartial", 16'(SAC_PWR_PARTIAL), 16'(powerMode));
    cmpVec("enPartial", 16'h0000, {15'h0, dataOutEn});
    conv(15, 1'b0, 1'b0);
    cmpVec("pwrWake", 16'(SAC_PWR_NORMAL), 16'(powerMode));
    cmpVec("restartOn", 16'h0001, {15'h0, restartBusy});
    conv(15, 1'b0, 1'b0);
    cmpVec("restartOff", 16'h0000, {15'h0, restartBusy});
    sac_host_model_i.frame(5, 8);
    sac_host_model_i.frame(5, 8);
    cmpVec("pwrFull", 16'(SAC_PWR_FULL), 16'(powerMode));
    // reference settling after full power-down is not modelled; the wake result is just not trusted
    conv(15, 1'b0, 1'b0);
    cmpVec("pwrWakeFull", 16'(SAC_PWR_NORMAL), 16'(powerMode));
    cmpVec("restartFull", 16'h0000, {15'h0, restartBusy});
    conv(15, 1'b1, 1'b1);
    repeat (40) @(posedge sys_clk);
    #1;
    cmpVec("queueLeft", 16'h0000, 16'(expQ.size()));
    $display("test power done");
    finish_test();
  end
endmodule // tb
